/* hdl/wakeup_lowv_ctrl.sv */
/*
 * Periodic wakeup timer and low-voltage detect control, with an AXI4-Lite register slave,
 * sticky event status, interrupt mask and one combined interrupt.
 * Assumes one 100 MHz clock, an asynchronous comparator level, and stop mode from logic on clk.
 */
// Summary of operation
// R1 - Timer end of period sets timeout flag
// R2 - Ack write of 1 clears flag
// R3 - Clock select: 0 slow, 1 fast
// R4 - Interrupt enable gates timeout interrupt
// R5 - Period code zero disables timer
// R6 - Slow source periods 8 to 1024 ticks
// R7 - Fast source periods 256 to 32768 ticks
// R8 - First timeout may come early
// R9 - Detect event sets flag while enabled
// R10 - Low-voltage ack write clears flag
// R11 - Interrupt enable requests interrupt on flag
// R12 - Reset enable forces reset on flag
// R13 - Stop enable keeps detection during stop
// R14 - Detect enable gates whole detector
// R15 - Bandgap buffer enable bit drives buffer
// R16 - Write-once bits accept first write only
// R17 - Software writes reserved bit as zero
// R18 - Comparator input synchronised, used as event
`timescale 1ns/10ps
`default_nettype none

module wakeup_lowv_ctrl #(
   parameter int SLOW_TICK_CYCLES = sysctl_pkg::SLOW_TICK_CYCLES,
   parameter int FAST_TICK_CYCLES = sysctl_pkg::FAST_TICK_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   // AXI4-Lite slave
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [11:0] awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [11:0] araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   // System side
   input  wire logic        lowVoltRaw,
   input  wire logic        stopMode,
   output logic             wakeupIrq,
   output logic             lowVoltIrq,
   output logic             lowVoltResetReq,
   output logic             lowVoltDetectorOn,
   output logic             bandgapBufferEnable,
   output logic             irq
);

   // ==========================================================================
   // Declarations
   sysctl_pkg::wakeup_ctrl_t             wake_q;
   sysctl_pkg::lowv_ctrl_t               lowv_q;
   logic [sysctl_pkg::EVT_W-1:0]         status_q;
   logic [sysctl_pkg::EVT_W-1:0]         mask_q;
   logic                                 detectWritten_q;
   logic                                 resetWritten_q;
   logic [15:0]                          wakeCount_q;
   logic [15:0]                          periodTicks;
   logic                                 slowTick;
   logic                                 fastTick;
   logic                                 srcTick;
   logic                                 timeout;
   logic                                 lowVoltSync;
   logic                                 detectActive;
   logic                                 lowVoltSet;
   logic                                 awHeld_q;
   logic                                 wHeld_q;
   logic [11:0]                          wrAddr_q;
   logic [31:0]                          wrData_q;
   logic [3:0]                           wrStrb_q;
   logic                                 wrFire;
   logic                                 wrLane0;
   logic                                 wrWake;
   logic                                 wrLowv;
   logic                                 wrStatus;
   logic                                 wrMask;
   logic [7:0]                           wrByte;
   logic [31:0]                          rdWord;
   logic                                 rdHit;

   // ==========================================================================
   // Slow and fast tick sources
   tick_divider #(
      .DIV (SLOW_TICK_CYCLES)
   ) u_slow_div (
      .clk  (clk),
      .rstn (rstn),
      .tick (slowTick)
   );

   tick_divider #(
      .DIV (FAST_TICK_CYCLES)
   ) u_fast_div (
      .clk  (clk),
      .rstn (rstn),
      .tick (fastTick)
   );

   // Comparator level into clk domain
   level_sync u_lowv_sync (
      .clk   (clk),
      .rstn  (rstn),
      .async (lowVoltRaw),
      .sync  (lowVoltSync)
   ); // R18

   // ==========================================================================
   // AXI write channel
   assign awready = !awHeld_q && !bvalid;
   assign wready  = !wHeld_q && !bvalid;
   assign wrFire  = awHeld_q && wHeld_q && !bvalid;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         awHeld_q <= 1'b0;
         wrAddr_q <= 12'h000;
      end else if (awvalid && awready) begin
         awHeld_q <= 1'b1;
         wrAddr_q <= awaddr;
      end else if (wrFire) begin
         awHeld_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wHeld_q  <= 1'b0;
         wrData_q <= 32'h0000_0000;
         wrStrb_q <= 4'h0;
      end else if (wvalid && wready) begin
         wHeld_q  <= 1'b1;
         wrData_q <= wdata;
         wrStrb_q <= wstrb;
      end else if (wrFire) begin
         wHeld_q <= 1'b0;
      end
   end

   // Write decode
   always_comb begin
      wrWake   = 1'b0;
      wrLowv   = 1'b0;
      wrStatus = 1'b0;
      wrMask   = 1'b0;
      if (wrAddr_q == sysctl_pkg::WAKEUP_CTRL_OFFS) begin
         wrWake = 1'b1;
      end else if (wrAddr_q == sysctl_pkg::LOWV_CTRL_OFFS) begin
         wrLowv = 1'b1;
      end else if (wrAddr_q == sysctl_pkg::IRQ_STATUS_OFFS) begin
         wrStatus = 1'b1;
      end else if (wrAddr_q == sysctl_pkg::IRQ_MASK_OFFS) begin
         wrMask = 1'b1;
      end
   end

   assign wrLane0 = wrFire && wrStrb_q[0];
   assign wrByte  = wrData_q[7:0];

   always_ff @(posedge clk) begin
      if (!rstn) begin
         bvalid <= 1'b0;
         bresp  <= sysctl_pkg::RESP_OKAY;
      end else if (wrFire) begin
         bvalid <= 1'b1;
         bresp  <= (wrWake || wrLowv || wrStatus || wrMask) ?
                   sysctl_pkg::RESP_OKAY : sysctl_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ==========================================================================
   // AXI read channel
   assign arready = !rvalid;

   always_comb begin
      rdWord = 32'h0000_0000;
      rdHit  = 1'b1;
      if (araddr == sysctl_pkg::WAKEUP_CTRL_OFFS) begin
         rdWord[7:0] = {wake_q.flag, 1'b0, wake_q.clkSel, wake_q.irqEn, 1'b0,
                        wake_q.period}; // R2
      end else if (araddr == sysctl_pkg::LOWV_CTRL_OFFS) begin
         rdWord[7:0] = {lowv_q.flag, 1'b0, lowv_q.irqEn, lowv_q.resetEn, lowv_q.stopEn,
                        lowv_q.detectEn, 1'b0, lowv_q.bandgapEn}; // R10
      end else if (araddr == sysctl_pkg::IRQ_STATUS_OFFS) begin
         rdWord[sysctl_pkg::EVT_W-1:0] = status_q;
      end else if (araddr == sysctl_pkg::IRQ_MASK_OFFS) begin
         rdWord[sysctl_pkg::EVT_W-1:0] = mask_q;
      end else begin
         rdHit = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= sysctl_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= rdWord;
         rresp  <= rdHit ? sysctl_pkg::RESP_OKAY : sysctl_pkg::RESP_SLVERR;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // ==========================================================================
   // Wakeup timer control fields
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wake_q.clkSel <= sysctl_pkg::WAKEUP_CTRL_RST[sysctl_pkg::WAKE_CLKS_BIT];
         wake_q.irqEn  <= sysctl_pkg::WAKEUP_CTRL_RST[sysctl_pkg::WAKE_IE_BIT];
         wake_q.period <= sysctl_pkg::WAKEUP_CTRL_RST[2:0];
      end else if (wrLane0 && wrWake) begin
         wake_q.clkSel <= wrByte[sysctl_pkg::WAKE_CLKS_BIT]; // R3
         wake_q.irqEn  <= wrByte[sysctl_pkg::WAKE_IE_BIT]; // R4
         wake_q.period <= wrByte[2:0];
      end
   end

   // Write-only and reserved positions hold nothing
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wake_q.ack  <= 1'b0;
         wake_q.rsvd <= 1'b0;
         lowv_q.ack  <= 1'b0;
         lowv_q.rsvd <= 1'b0;
      end
   end

   // Timeout flag, set wins over ack
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wake_q.flag <= sysctl_pkg::WAKEUP_CTRL_RST[sysctl_pkg::FLAG_BIT];
      end else if (timeout) begin
         wake_q.flag <= 1'b1; // R1
      end else if (wrLane0 && wrWake && wrByte[sysctl_pkg::ACK_BIT]) begin
         wake_q.flag <= 1'b0; // R2
      end
   end

   // ==========================================================================
   // Wakeup timer counter
   assign srcTick     = wake_q.clkSel ? fastTick : slowTick; // R3
   assign periodTicks = wake_q.clkSel ?
                        (sysctl_pkg::WAKE_PERIOD_TICKS[wake_q.period] << sysctl_pkg::FAST_SHIFT)
                        : sysctl_pkg::WAKE_PERIOD_TICKS[wake_q.period]; // R6 R7
   // Dividers run free, so the first period may be short by part of a tick
   assign timeout = srcTick && (wake_q.period != 3'h0)
                    && (wakeCount_q >= periodTicks - 16'h0001); // R8

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wakeCount_q <= 16'h0000;
      end else if (wake_q.period == 3'h0) begin
         wakeCount_q <= 16'h0000; // R5
      end else if (timeout) begin
         wakeCount_q <= 16'h0000;
      end else if (srcTick) begin
         wakeCount_q <= wakeCount_q + 16'h0001;
      end
   end

   assign wakeupIrq = wake_q.flag && wake_q.irqEn; // R4

   // ==========================================================================
   // Low-voltage control fields
   always_ff @(posedge clk) begin
      if (!rstn) begin
         lowv_q.irqEn     <= sysctl_pkg::LOWV_CTRL_RST[sysctl_pkg::LV_IE_BIT];
         lowv_q.stopEn    <= sysctl_pkg::LOWV_CTRL_RST[sysctl_pkg::LV_SE_BIT];
         lowv_q.bandgapEn <= sysctl_pkg::LOWV_CTRL_RST[sysctl_pkg::LV_BANDGAP_BUFFER_ENABLE_BIT];
      end else if (wrLane0 && wrLowv) begin
         lowv_q.irqEn     <= wrByte[sysctl_pkg::LV_IE_BIT]; // R11
         lowv_q.stopEn    <= wrByte[sysctl_pkg::LV_SE_BIT]; // R13
         lowv_q.bandgapEn <= wrByte[sysctl_pkg::LV_BANDGAP_BUFFER_ENABLE_BIT]; // R15
      end
   end

   // Write-once bits
   always_ff @(posedge clk) begin
      if (!rstn) begin
         lowv_q.detectEn <= sysctl_pkg::LOWV_CTRL_RST[sysctl_pkg::LV_DE_BIT];
         detectWritten_q <= 1'b0;
      end else if (wrLane0 && wrLowv && !detectWritten_q) begin
         lowv_q.detectEn <= wrByte[sysctl_pkg::LV_DE_BIT]; // R14
         detectWritten_q <= 1'b1; // R16
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         lowv_q.resetEn <= sysctl_pkg::LOWV_CTRL_RST[sysctl_pkg::LV_RE_BIT];
         resetWritten_q <= 1'b0;
      end else if (wrLane0 && wrLowv && !resetWritten_q) begin
         lowv_q.resetEn <= wrByte[sysctl_pkg::LV_RE_BIT]; // R12
         resetWritten_q <= 1'b1; // R16
      end
   end

   // ==========================================================================
   // Low-voltage detector
   assign detectActive = lowv_q.detectEn && (!stopMode || lowv_q.stopEn); // R13 R14
   assign lowVoltSet   = detectActive && lowVoltSync; // R9 R18

   always_ff @(posedge clk) begin
      if (!rstn) begin
         lowv_q.flag <= sysctl_pkg::LOWV_CTRL_RST[sysctl_pkg::FLAG_BIT];
      end else if (lowVoltSet) begin
         lowv_q.flag <= 1'b1; // R9
      end else if (wrLane0 && wrLowv && wrByte[sysctl_pkg::ACK_BIT]) begin
         lowv_q.flag <= 1'b0; // R10
      end
   end

   assign lowVoltIrq          = lowv_q.flag && lowv_q.irqEn; // R11
   assign lowVoltResetReq     = lowv_q.flag && lowv_q.resetEn && lowv_q.detectEn; // R12 R14
   assign lowVoltDetectorOn   = detectActive; // R14
   assign bandgapBufferEnable = lowv_q.bandgapEn; // R15

   // ==========================================================================
   // Sticky event status and mask
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mask_q <= sysctl_pkg::IRQ_MASK_RST;
      end else if (wrLane0 && wrMask) begin
         mask_q <= wrByte[sysctl_pkg::EVT_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         status_q <= '0;
      end else begin
         if (timeout) begin
            status_q[sysctl_pkg::EVT_WAKE_BIT] <= 1'b1;
         end else if (wrLane0 && wrStatus && wrByte[sysctl_pkg::EVT_WAKE_BIT]) begin
            status_q[sysctl_pkg::EVT_WAKE_BIT] <= 1'b0;
         end
         if (lowVoltSet) begin
            status_q[sysctl_pkg::EVT_LOWV_BIT] <= 1'b1;
         end else if (wrLane0 && wrStatus && wrByte[sysctl_pkg::EVT_LOWV_BIT]) begin
            status_q[sysctl_pkg::EVT_LOWV_BIT] <= 1'b0;
         end
      end
   end

   assign irq = |(status_q & mask_q);

endmodule : wakeup_lowv_ctrl

`default_nettype wire

/* hdl/sysctl_pkg.sv */
/*
 * Shared constants and carriers of the wakeup timer and low-voltage control block:
 * register offsets, field positions, reset values, timing counts, packed register images.
 * Assumes a 100 MHz bus clock and a 32-bit AXI4-Lite register bus.
 */
package sysctl_pkg;

   // ==========================================================================
   // Register map
   localparam logic [11:0] WAKEUP_CTRL_OFFS = 12'h000;
   localparam logic [11:0] LOWV_CTRL_OFFS   = 12'h004;
   localparam logic [11:0] IRQ_STATUS_OFFS  = 12'h008;
   localparam logic [11:0] IRQ_MASK_OFFS    = 12'h00C;

   // ==========================================================================
   // Field positions
   localparam int FLAG_BIT      = 7;
   localparam int ACK_BIT       = 6;
   localparam int WAKE_CLKS_BIT = 5;
   localparam int WAKE_IE_BIT   = 4;
   localparam int LV_IE_BIT     = 5;
   localparam int LV_RE_BIT     = 4;
   localparam int LV_SE_BIT     = 3;
   localparam int LV_DE_BIT     = 2;
   localparam int LV_RSVD_BIT   = 1;
   localparam int LV_BANDGAP_BUFFER_ENABLE_BIT   = 0;
   localparam int EVT_WAKE_BIT  = 0;
   localparam int EVT_LOWV_BIT  = 1;
   localparam int EVT_W         = 2;

   // ==========================================================================
   // Reset values
   localparam logic [7:0]       WAKEUP_CTRL_RST = 8'h00;
   localparam logic [7:0]       LOWV_CTRL_RST   = 8'h00;
   localparam logic [EVT_W-1:0] IRQ_MASK_RST    = 2'h0;

   // ==========================================================================
   // Timing
   localparam int CLK_PERIOD_NS  = 10;
   localparam int SLOW_PERIOD_NS = 1000000;
   localparam int FAST_PERIOD_NS = 31250;
   localparam int SLOW_TICK_CYCLES = SLOW_PERIOD_NS / CLK_PERIOD_NS;
   localparam int FAST_TICK_CYCLES = FAST_PERIOD_NS / CLK_PERIOD_NS;
   localparam int FAST_SHIFT = 5;
   localparam logic [15:0] WAKE_PERIOD_TICKS [0:7] = '{
      16'h0000, 16'h0008, 16'h0020, 16'h0040, 16'h0080, 16'h0100, 16'h0200, 16'h0400};

   // ==========================================================================
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================================
   // Register images
   typedef struct packed {
      logic       flag;
      logic       ack;
      logic       clkSel;
      logic       irqEn;
      logic       rsvd;
      logic [2:0] period;
   } wakeup_ctrl_t;

   typedef struct packed {
      logic flag;
      logic ack;
      logic irqEn;
      logic resetEn;
      logic stopEn;
      logic detectEn;
      logic rsvd;
      logic bandgapEn;
   } lowv_ctrl_t;

endpackage : sysctl_pkg

/* hdl/level_sync.sv */
/*
 * Two-flip-flop synchroniser for one asynchronous level.
 * Assumes the input is a slowly changing level, not a short pulse.
 */
`timescale 1ns/10ps
`default_nettype none

module level_sync (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic async,
   output logic      sync
);

   logic meta_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta_q <= 1'b0;
         sync   <= 1'b0;
      end else begin
         meta_q <= async;
         sync   <= meta_q;
      end
   end

endmodule : level_sync

`default_nettype wire

/* hdl/tick_divider.sv */
/*
 * Free-running divider giving a one-cycle enable pulse every DIV clock cycles.
 * Assumes DIV is at least 2.
 */
`timescale 1ns/10ps
`default_nettype none

module tick_divider #(
   parameter int DIV = 100000
) (
   input  wire logic clk,
   input  wire logic rstn,
   output logic      tick
);

   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] count_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         count_q <= '0;
         tick    <= 1'b0;
      end else begin
         tick    <= (count_q == LAST);
         count_q <= (count_q == LAST) ? '0 : count_q + CW'(1);
      end
   end

endmodule : tick_divider

`default_nettype wire

/* tb/wakeup_lowv_ctrl_props.sv */
/*
 * Checker of the wakeup timer and low-voltage control block: bus handshakes and outputs.
 * Assumes only the top module's ports; bound to every wakeup_lowv_ctrl instance.
 */
`timescale 1ns/10ps
`default_nettype none

module wakeup_lowv_ctrl_props (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic [31:0] rdata,
   input wire logic        stopMode,
   input wire logic        wakeupIrq,
   input wire logic        lowVoltIrq,
   input wire logic        lowVoltResetReq,
   input wire logic        lowVoltDetectorOn,
   input wire logic        bandgapBufferEnable,
   input wire logic        irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // ==========================================================================
   // Bus steps
   sequence wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence resp_waiting;
      bvalid && !bready;
   endsequence

   // ==========================================================================
   // Properties
   a_write_answer: assert property (wr_taken |-> ##2 bvalid)
      else $error("write response missing");
   a_bresp_held: assert property (resp_waiting |=> bvalid)
      else $error("write response dropped");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data missing");
   a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_detector_cause: assert property (
      $changed(lowVoltDetectorOn) |-> $changed(stopMode) || $rose(bvalid))
      else $error("detector changed without cause");
   a_bandgap_write: assert property ($changed(bandgapBufferEnable) |-> $rose(bvalid))
      else $error("bandgap enable changed without write");
   a_lowv_irq_source: assert property (
      $rose(lowVoltIrq) |-> $rose(bvalid) || $past(lowVoltDetectorOn))
      else $error("low-voltage interrupt while detector off");
   a_flag_clear_write: assert property (
      $fell(wakeupIrq) || $fell(lowVoltIrq) || $fell(irq) |-> $rose(bvalid))
      else $error("interrupt fell without write");
   a_reset_req_gate: assert property (
      $rose(lowVoltResetReq) |-> $rose(bvalid) || $past(lowVoltDetectorOn))
      else $error("reset request with detector off");
endmodule : wakeup_lowv_ctrl_props

bind wakeup_lowv_ctrl wakeup_lowv_ctrl_props u_props (
   .clk(clk), .rstn(rstn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
   .rvalid(rvalid), .rready(rready), .rdata(rdata), .stopMode(stopMode),
   .wakeupIrq(wakeupIrq), .lowVoltIrq(lowVoltIrq), .lowVoltResetReq(lowVoltResetReq),
   .lowVoltDetectorOn(lowVoltDetectorOn), .bandgapBufferEnable(bandgapBufferEnable),
   .irq(irq));

`default_nettype wire

/* tb/wakeup_lowv_ctrl_tb.sv */
/*
 * Self-checking bench of wakeup_lowv_ctrl over AXI4-Lite, with shortened tick dividers.
 * Assumes the design package and modules are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module wakeup_lowv_ctrl_tb;
   localparam int SLOW  = 20;
   localparam int FAST  = 4;
   localparam int LIMIT = 90000;
   logic clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, lowVoltRaw = 1'b0, stopMode = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata  = 32'h0;
   logic        awready, wready, bvalid, arready, rvalid, wakeupIrq, lowVoltIrq;
   logic        lowVoltResetReq, lowVoltDetectorOn, bandgapBufferEnable, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          nErrors = 0, checksDone = 0, cycles = 0;

   wakeup_lowv_ctrl #(.SLOW_TICK_CYCLES(SLOW), .FAST_TICK_CYCLES(FAST)) dut (
      .clk(clk), .rstn(rstn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .lowVoltRaw(lowVoltRaw), .stopMode(stopMode), .wakeupIrq(wakeupIrq),
      .lowVoltIrq(lowVoltIrq), .lowVoltResetReq(lowVoltResetReq),
      .lowVoltDetectorOn(lowVoltDetectorOn), .bandgapBufferEnable(bandgapBufferEnable),
      .irq(irq));

   always #5 clk = ~clk;

   // ==========================================================================
   // Common tasks
   task automatic completeRun;
      if (nErrors == 0 && checksDone > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : completeRun

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         nErrors++;
         $display("[FAIL] %0t run too long", $time);
         completeRun();
      end
   end

   task automatic ok(input logic c, input string what);
      checksDone++;
      if (c !== 1'b1) begin
         nErrors++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask : ok

   task automatic do_reset;
      rstn <= 1'b0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
   endtask : do_reset

   // Handshakes sampled at the falling edge, released by the next rising edge
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      logic awT, wT, done;
      done = 1'b0;
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= {24'h0, d};
      while (!done) begin
         @(negedge clk);
         awT  = awvalid && awready;
         wT   = wvalid && wready;
         done = bvalid;
         @(posedge clk);
         if (awT) awvalid <= 1'b0;
         if (wT) wvalid <= 1'b0;
      end
      bready <= 1'b1;
      @(negedge clk);
      ok(bvalid === 1'b1 && bresp === er, "write response code");
      @(posedge clk);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
      logic arT, done;
      done = 1'b0;
      @(posedge clk);
      arvalid <= 1'b1;
      araddr  <= a;
      while (!done) begin
         @(negedge clk);
         arT  = arvalid && arready;
         done = rvalid;
         @(posedge clk);
         if (arT) arvalid <= 1'b0;
      end
      rready <= 1'b1;
      @(negedge clk);
      ok(rvalid === 1'b1 && rdata === {24'h0, e} && rresp === er, "read data or code");
      @(posedge clk);
      rready <= 1'b0;
   endtask : rd

   task automatic wait_wake(input int lim);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (wakeupIrq !== 1'b1 && n < lim);
   endtask : wait_wake

   // ==========================================================================
   // Scenarios
   task automatic t_regs;
      rd(12'h000, 8'h00, 2'h0);
      rd(12'h004, 8'h00, 2'h0);
      rd(12'h008, 8'h00, 2'h0);
      rd(12'h00C, 8'h00, 2'h0);
      rd(12'h010, 8'h00, 2'h2);
      wr(12'h010, 8'hFF, 2'h2);
      ok({irq, lowVoltResetReq, bandgapBufferEnable} === 3'h0, "outputs after reset");
   endtask : t_regs

   task automatic t_timer;
      int tab[8] = '{0, 8, 32, 64, 128, 256, 512, 1024};
      int e, t0;
      logic [7:0] c;
      for (int k = 0; k < 10; k++) begin
         c = (k < 7) ? 8'(8'h11 + k) : 8'(8'h2A + k);
         e = tab[k < 7 ? k + 1 : k - 6] * (k < 7 ? SLOW : 32 * FAST);
         wr(12'h000, 8'h40, 2'h0);
         wr(12'h000, c, 2'h0);
         t0 = cycles;
         wait_wake(e + SLOW);
         ok(cycles - t0 >= e - SLOW - 3 && cycles - t0 <= e + 3, "first timeout");
         if (k == 0 || k == 7) begin
            t0 = cycles;
            wr(12'h000, c | 8'h40, 2'h0);
            rd(12'h000, c, 2'h0);
            wait_wake(e + SLOW);
            ok(cycles - t0 == e, "timeout period");
         end
      end
   endtask : t_timer

   task automatic t_poll;
      wr(12'h000, 8'h40, 2'h0);
      wr(12'h008, 8'h01, 2'h0);
      wr(12'h000, 8'h01, 2'h0);
      repeat (8 * SLOW + 10) @(posedge clk);
      ok(wakeupIrq === 1'b0 && irq === 1'b0, "interrupt while disabled");
      wr(12'h000, 8'h01, 2'h0);
      rd(12'h000, 8'h81, 2'h0);
      wr(12'h00C, 8'h01, 2'h0);
      rd(12'h00C, 8'h01, 2'h0);
      ok(irq === 1'b1, "masked status interrupt");
      wr(12'h000, 8'h60, 2'h0);
      wr(12'h008, 8'h01, 2'h0);
      ok(irq === 1'b0, "status clear");
      repeat (8 * 32 * FAST + 10) @(posedge clk);
      rd(12'h000, 8'h20, 2'h0);
      rd(12'h008, 8'h00, 2'h0);
   endtask : t_poll

   task automatic t_lowv;
      lowVoltRaw <= 1'b1;
      repeat (6) @(posedge clk);
      rd(12'h004, 8'h00, 2'h0);
      wr(12'h004, 8'h3D, 2'h0);
      repeat (4) @(posedge clk);
      ok({lowVoltIrq, lowVoltResetReq, lowVoltDetectorOn, bandgapBufferEnable} === 4'hF,
         "low-voltage outputs");
      rd(12'h004, 8'hBD, 2'h0);
      lowVoltRaw <= 1'b0;
      repeat (4) @(posedge clk);
      wr(12'h004, 8'h7D, 2'h0);
      rd(12'h004, 8'h3D, 2'h0);
      wr(12'h004, 8'h00, 2'h0);
      rd(12'h004, 8'h14, 2'h0);
      ok({lowVoltIrq, bandgapBufferEnable} === 2'h0, "enables cleared");
      stopMode <= 1'b1;
      lowVoltRaw <= 1'b1;
      repeat (6) @(posedge clk);
      ok({lowVoltDetectorOn, lowVoltResetReq} === 2'h0, "detector off in stop");
      rd(12'h004, 8'h14, 2'h0);
      wr(12'h004, 8'h08, 2'h0);
      repeat (4) @(posedge clk);
      ok({lowVoltDetectorOn, lowVoltResetReq, lowVoltIrq} === 3'h6, "stop detect");
      rd(12'h004, 8'h9C, 2'h0);
      stopMode <= 1'b0;
      rd(12'h008, 8'h02, 2'h0);
      wr(12'h00C, 8'h02, 2'h0);
      ok(irq === 1'b1, "low-voltage status interrupt");
   endtask : t_lowv

   task automatic t_once;
      do_reset();
      ok({lowVoltResetReq, lowVoltDetectorOn, irq} === 3'h0, "outputs after second reset");
      wr(12'h004, 8'h00, 2'h0);
      wr(12'h004, 8'h14, 2'h0);
      repeat (4) @(posedge clk);
      rd(12'h004, 8'h00, 2'h0);
      ok(lowVoltDetectorOn === 1'b0, "detector stays off");
   endtask : t_once

   initial begin
      do_reset();
      t_regs();
      t_timer();
      t_poll();
      t_lowv();
      t_once();
      completeRun();
   end
endmodule : wakeup_lowv_ctrl_tb

`default_nettype wire
